// [logic/adcsp_port.sv]
// Function
// - host mode: data changes on falling edge
// - mode high: early deselect finishes bit, then releases pins
// - select ignored during four-cycle load pulse
// - mode low: host clock, input, MSB first
// - mode high: drive clock, quarter rate, 25%
// - select pins captured on calibrate rising edge
// - select b low means system calibration
// - bipolar output code is offset binary
// - calibrate held over four cycles resets
// - data-ready low while valid, load pulses high
// - select low starts sending held word
// - standby low stops conversion
`timescale 1ns/1ns
`default_nettype none
`include "adcsp_defines.svh"
module adcsp_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk_pin_i,
	output logic sclk_pin_o,
	output logic sclk_pin_oe_n,
	output logic serial_out_pin,
	output logic serial_out_pin_oe_n,
	input wire logic mode_pin,
	input wire logic cs_n_pin,
	input wire logic standby_n_pin,
	input wire logic bipolar_pin,
	input wire logic cal_pin,
	input wire logic cal_select_a,
	input wire logic cal_select_b,
	input wire logic result_valid,
	output logic result_ready,
	input wire logic [`ADCSP_WORD_BITS-1:0] result_data,
	output logic word_valid_n,
	output logic conv_run,
	output logic cal_reset,
	output logic cal_start,
	output adcsp_pkg::adcsp_cal_type cal_kind
);
	import adcsp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation.

	// All control pins are asynchronous to the master clock.
	adcsp_pins_type pins;
	adcsp_sync2 #(.W(7)) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({mode_pin, cs_n_pin, standby_n_pin, bipolar_pin, cal_pin, cal_select_a, cal_select_b}),
		.q(pins)
	);

	////////////////////////////////////////////////////////////////////////
	// Calibration control.

	// Strobe history, hold counter and captured kind.
	logic cal_prev_q;
	logic [2:0] cal_cnt_q;
	logic cal_reset_q;
	logic cal_start_q;
	adcsp_cal_type cal_kind_q;
	wire cal_rise = pins.cal && !cal_prev_q;
	wire cal_fall = !pins.cal && cal_prev_q;
	wire cal_long = (cal_cnt_q == `ADCSP_CAL_HOLD);

	// capture select pins.
	// The selects are synchronised alongside the strobe, so the captured
	// level is the one present when the strobe was seen rising.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_prev_q <= 1'b0;
			cal_kind_q <= '0;
		end else begin
			cal_prev_q <= pins.cal;
			if (cal_rise) cal_kind_q <= '{system_cal: !pins.cal_select_b, sel_a: pins.cal_select_a};
		end
	end

	// long strobe resets.
	// A strobe of four cycles or less is only a synchronising pulse.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_cnt_q <= 3'h0;
			cal_reset_q <= 1'b0;
			cal_start_q <= 1'b0;
		end else begin
			cal_cnt_q <= !pins.cal ? 3'h0 : (cal_long ? cal_cnt_q : cal_cnt_q + 3'h1);
			cal_reset_q <= pins.cal && cal_long;
			cal_start_q <= cal_fall && cal_reset_q;
		end
	end

	assign cal_reset = cal_reset_q;
	assign cal_start = cal_start_q;
	assign cal_kind = cal_kind_q;

	// standby stops conversion.
	// The master clock is still needed here in standby, since the
	// calibration state lives on it.
	assign conv_run = pins.run && !cal_reset_q;

	////////////////////////////////////////////////////////////////////////
	// Result buffer.

	// Two entries let the filter deliver while a word is on the pin.
	logic buf_valid;
	logic buf_pop;
	logic [`ADCSP_WORD_BITS-1:0] buf_data;
	adcsp_buf2 #(.W(`ADCSP_WORD_BITS)) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(result_valid && conv_run),
		.in_ready(result_ready),
		.in_data(result_data),
		.out_valid(buf_valid),
		.out_ready(buf_pop),
		.out_data(buf_data)
	);

	// offset binary in bipolar.
	// The filter delivers two's complement; flipping the top bit maps it.
	wire [`ADCSP_WORD_BITS-1:0] fmt_word = {buf_data[`ADCSP_WORD_BITS-1] ^ pins.bipolar,
		buf_data[`ADCSP_WORD_BITS-2:0]};

	////////////////////////////////////////////////////////////////////////
	// Sequencer.

	adcsp_state_type st_q;
	adcsp_state_type st_d;
	logic [`ADCSP_WORD_BITS-1:0] word_q; // Held output word.
	logic [2:0] ld_cnt_q;                // Load pulse length.
	logic [1:0] ph_q;                    // Self-clock divider phase.
	logic [4:0] idx_q;                   // Self-clock bit index.
	logic so_q;                          // Self-clock data flop.
	logic frame_q;                       // Flips at each host frame start.
	logic done_prev_q;
	logic done_sync;
	wire host_done = done_sync ^ done_prev_q;
	wire busy = (st_q == ST_SELF) || (st_q == ST_HOST);
	wire ph_end = (ph_q == `ADCSP_SCLK_END_PH);
	wire last_bit = (idx_q == `ADCSP_LAST_BIT);
	wire ld_end = (ld_cnt_q == `ADCSP_LOAD_CYCLES - 3'h1);

	assign buf_pop = buf_valid && !busy && (st_q != ST_LOAD) && !cal_reset_q;

	// Next-state decode.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_EMPTY: begin
				if (buf_pop) st_d = ST_LOAD;
			end
			ST_LOAD: begin
				if (ld_end) st_d = ST_READY;
			end
			ST_READY: begin
				if (buf_pop) begin
					st_d = ST_LOAD;
				end else if (!pins.cs_high) begin
					st_d = pins.self_clocked_mode ? ST_SELF : ST_HOST;
				end
			end
			ST_SELF: begin
				if (ph_end && last_bit) st_d = ST_EMPTY;
				else if (ph_end && pins.cs_high) st_d = ST_READY;
			end
			ST_HOST: begin
				if (host_done) st_d = ST_EMPTY;
				else if (pins.cs_high) st_d = ST_READY;
			end
		endcase
		if (cal_reset_q) st_d = ST_EMPTY;
	end

	// State, word and load counter.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= ST_EMPTY;
			word_q <= '0;
			ld_cnt_q <= 3'h0;
			frame_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (buf_pop) word_q <= fmt_word;
			ld_cnt_q <= (st_q == ST_LOAD) ? ld_cnt_q + 3'h1 : 3'h0;
			if (st_d == ST_HOST && st_q != ST_HOST) frame_q <= ~frame_q;
		end
	end

	// quarter-rate clock divider.
	// Each bit spans four master clocks; data changes at phase 0, the
	// clock is high only in phase 2 and falls at the end of phase 2.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ph_q <= 2'h0;
			idx_q <= 5'h0;
			so_q <= 1'b0;
		end else if (st_q != ST_SELF) begin
			ph_q <= 2'h0;
			idx_q <= 5'h0;
			so_q <= word_q[`ADCSP_WORD_BITS-1];
		end else begin
			ph_q <= ph_q + 2'h1;
			if (ph_end && !last_bit) begin
				idx_q <= idx_q + 5'h1;
				so_q <= word_q[5'(`ADCSP_LAST_BIT - 5'(idx_q + 5'h1))];
			end
		end
	end

	// data-ready flag.
	// High during the load pulse and once the word has been sent.
	assign word_valid_n = !((st_q == ST_READY) || busy);

	assign sclk_pin_oe_n = (st_q != ST_SELF);
	assign sclk_pin_o = (st_q == ST_SELF) && (ph_q == `ADCSP_SCLK_HI_PH);

	assign serial_out_pin_oe_n = !busy;

	////////////////////////////////////////////////////////////////////////
	// Host-clocked link domain.

	// Reset reaches the link domain through its own synchroniser.
	logic lrst_n;
	adcsp_sync2 #(.W(1)) u_lrst_sync (
		.clk(sclk_pin_i),
		.rst_n(1'b1),
		.d(rst_n),
		.q(lrst_n)
	);

	logic lframe_q;           // Last frame seen on the link side.
	logic [4:0] lcnt_q;       // Falling edges seen in this frame.
	logic ldone_q;            // Toggles when a whole word is out.
	wire lnew = (lframe_q != frame_q);

	// count bits on falling edges.
	// The frame toggle and word are static for four master clocks plus
	// the host setup time before the first edge, so they are read here
	// without a synchroniser; the host keeps that spacing.
	always_ff @(negedge sclk_pin_i) begin
		if (!lrst_n) begin
			lframe_q <= 1'b0;
			lcnt_q <= 5'h0;
			ldone_q <= 1'b0;
		end else if (lnew) begin
			lframe_q <= frame_q;
			lcnt_q <= 5'h1;
		end else if (lcnt_q <= `ADCSP_LAST_BIT) begin
			lcnt_q <= lcnt_q + 5'h1;
			if (lcnt_q == `ADCSP_LAST_BIT) ldone_q <= ~ldone_q;
		end
	end

	// Completion toggle back into the master domain.
	adcsp_sync2 #(.W(1)) u_done_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(ldone_q),
		.q(done_sync)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) done_prev_q <= 1'b0;
		else done_prev_q <= done_sync;
	end

	// Host-mode bit select; MSB stands before the first falling edge.
	wire [4:0] hidx = (lnew || lcnt_q > `ADCSP_LAST_BIT) ? 5'h0 : lcnt_q;
	wire host_bit = word_q[5'(`ADCSP_LAST_BIT - hidx)];
	assign serial_out_pin = (st_q == ST_HOST) ? host_bit : so_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	load_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_LOAD && $past(st_q) != ST_LOAD) |-> word_valid_n [*4] ##1 !word_valid_n || $past(cal_reset_q, 1) || cal_reset_q)
		else $error("data-ready load pulse is not four cycles");
	load_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_LOAD) |=> !busy)
		else $error("transfer started during load pulse");
	self_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
		(sclk_pin_o && st_q == ST_SELF) |=> !sclk_pin_o ##1 !sclk_pin_o ##1 !sclk_pin_o)
		else $error("self clock duty is not 25 percent");
	host_input_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_HOST) |-> sclk_pin_oe_n && !serial_out_pin_oe_n)
		else $error("clock driven in host-clocked mode");
	abort_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_SELF && pins.cs_high && !ph_end) |=> (st_q == ST_SELF) || $past(cal_reset_q))
		else $error("bit cut short on deselect");
	word_end_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_SELF && ph_end && last_bit && !cal_reset_q) |=> word_valid_n && serial_out_pin_oe_n && sclk_pin_oe_n)
		else $error("pins not released after last bit");
	word_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		busy |=> $stable(word_q))
		else $error("word changed during transfer");
	cal_kind_a: assert property (@(posedge clk) disable iff (!rst_n)
		cal_rise |=> cal_kind_q.system_cal == !$past(pins.cal_select_b))
		else $error("calibration kind not captured");
	cal_long_a: assert property (@(posedge clk) disable iff (!rst_n)
		pins.cal [*6] |-> cal_reset_q ##1 word_valid_n)
		else $error("long calibrate strobe did not reset");
	standby_a: assert property (@(posedge clk) disable iff (!rst_n)
		!pins.run |-> !conv_run && !u_buf.push)
		else $error("conversion runs in standby");
	cs_start_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st_q == ST_READY && !pins.cs_high && !buf_valid && !cal_reset_q) |=> busy)
		else $error("select did not start transfer");
	// first falling edge moves to bit one.
	host_edge_a: assert property (@(negedge sclk_pin_i) disable iff (!lrst_n)
		lnew |=> lcnt_q == 5'h1)
		else $error("host edge did not advance bit");
endmodule : adcsp_port
`default_nettype wire

// [common/adcsp_defines.svh]
`ifndef ADCSP_DEFINES_SVH
`define ADCSP_DEFINES_SVH
// Length of one result word on the serial pin.
`define ADCSP_WORD_BITS 20
// Master-clock cycles for which the data-ready flag pulses high on a load.
`define ADCSP_LOAD_CYCLES 3'h4
// Calibrate strobe must stay high longer than this many cycles to reset.
`define ADCSP_CAL_HOLD 3'h4
// Self-clocked serial clock is the master clock divided by this.
`define ADCSP_SCLK_DIV 3'h4
// Divider phase in which the self-clocked serial clock is high.
`define ADCSP_SCLK_HI_PH 2'h2
// Last divider phase of a bit; the falling edge starts it.
`define ADCSP_SCLK_END_PH 2'h3
// Index of the last bit of a word.
`define ADCSP_LAST_BIT 5'h13
`endif

// [common/adcsp_pkg.sv]
`default_nettype none
package adcsp_pkg;

	// Main sequencer states, one-hot.
	typedef enum logic [4:0] {
		ST_EMPTY = 5'h01,
		ST_LOAD = 5'h02,
		ST_READY = 5'h04,
		ST_SELF = 5'h08,
		ST_HOST = 5'h10
	} adcsp_state_type;

	// Calibration kind captured on the rising calibrate strobe.
	typedef struct packed {
		logic system_cal;
		logic sel_a;
	} adcsp_cal_type;

	// Static control pins after synchronisation.
	typedef struct packed {
		logic self_clocked_mode;
		logic cs_high;
		logic run;
		logic bipolar;
		logic cal;
		logic cal_select_a;
		logic cal_select_b;
	} adcsp_pins_type;

endpackage : adcsp_pkg
`default_nettype wire

// [logic/adcsp_sync2.sv]
`timescale 1ns/1ns
`default_nettype none
// Two-flop level synchroniser; the first stage feeds only the second.
module adcsp_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// First stage, metastable on purpose.
	logic [W-1:0] meta_q;

	// Both stages clear on reset so downstream logic starts known.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : adcsp_sync2
`default_nettype wire

// [logic/adcsp_buf2.sv]
`timescale 1ns/1ns
`default_nettype none
// Two-entry valid/ready buffer; full stalls the producer.
module adcsp_buf2 #(
	parameter int W = 20
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	// Storage and pointers.
	logic [W-1:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rp_q];

	// Pointer and occupancy update; push and pop may share a cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) wp_q <= ~wp_q;
			if (pop) rp_q <= ~rp_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// Data storage has no reset; occupancy guards it.
	always_ff @(posedge clk) begin
		if (push) mem_q[wp_q] <= in_data;
	end
endmodule : adcsp_buf2
`default_nettype wire

// [test/adcsp_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Host at the far side: drives select and, in host-clocked mode, the link clock.
module adcsp_host_model (
	input wire logic clk,
	input wire logic sclk_pin_o,
	input wire logic sclk_pin_oe_n,
	input wire logic serial_out_pin,
	input wire logic serial_out_pin_oe_n,
	output logic sclk_pin_i,
	output logic cs_n_pin
);
	// Host's own drive of the serial clock line.
	logic host_q;
	// A released data line toggles, so a stale bit can never be read as good.
	wire logic data_line;
	assign data_line = serial_out_pin_oe_n ? clk : serial_out_pin;
	// The clock line carries whoever drives it.
	assign sclk_pin_i = sclk_pin_oe_n ? host_q : sclk_pin_o;
	initial begin
		host_q = 1'b0;
		cs_n_pin = 1'b1;
	end
	////////////////////////////////////////////////////////////
	// Free-running link clock, used only while the port is held in reset.
	task automatic run_clock(input int n);
		repeat (n) begin
			#3 host_q = 1'b1;
			#3 host_q = 1'b0;
		end
	endtask : run_clock
	// Lets go of select.
	task automatic deselect;
		cs_n_pin = 1'b1;
	endtask : deselect
	// Host-clocked read of n bits; a short read deselects after its last bit.
	task automatic read_host(input int n, output logic [19:0] w);
		w = 20'h00000;
		cs_n_pin = 1'b0;
		#(4 * 40 + 160);
		repeat (n) begin
			#3 host_q = 1'b1;
			w = {w[18:0], data_line};
			#3 host_q = 1'b0;
		end
		if (n < 20) begin
			cs_n_pin = 1'b1;
		end
	endtask : read_host
	// Self-clocked read of n bits: sample on each device clock rise, then deselect.
	task automatic read_self(input int n, output logic [19:0] w);
		w = 20'h00000;
		@(negedge clk) cs_n_pin = 1'b0;
		repeat (n) begin
			@(posedge sclk_pin_o iff !sclk_pin_oe_n);
			w = {w[18:0], data_line};
		end
		@(negedge clk) cs_n_pin = 1'b1;
	endtask : read_self
endmodule : adcsp_host_model
`default_nettype wire

// [test/adc_serial_port_and_cal_control_test.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_serial_port_and_cal_control_test;
	import adcsp_pkg::*;
	logic clk, rst_n, mode_pin, standby_n_pin, bipolar_pin, cal_pin, cal_select_a, cal_select_b;
	logic result_valid;
	logic [19:0] result_data, w;
	wire logic sclk_pin_i, sclk_pin_o, sclk_pin_oe_n, serial_out_pin, serial_out_pin_oe_n, cs_n_pin;
	wire logic result_ready, word_valid_n, conv_run, cal_reset, cal_start;
	adcsp_cal_type cal_kind;
	int err_count = 0, cmp_count = 0, cycles = 0, act_cnt, hi_cnt, cal_hits, start_cnt;
	adcsp_port DUT (.clk(clk), .rst_n(rst_n), .sclk_pin_i(sclk_pin_i), .sclk_pin_o(sclk_pin_o),
		.sclk_pin_oe_n(sclk_pin_oe_n), .serial_out_pin(serial_out_pin),
		.serial_out_pin_oe_n(serial_out_pin_oe_n), .mode_pin(mode_pin), .cs_n_pin(cs_n_pin),
		.standby_n_pin(standby_n_pin), .bipolar_pin(bipolar_pin), .cal_pin(cal_pin),
		.cal_select_a(cal_select_a), .cal_select_b(cal_select_b), .result_valid(result_valid),
		.result_ready(result_ready), .result_data(result_data), .word_valid_n(word_valid_n),
		.conv_run(conv_run), .cal_reset(cal_reset), .cal_start(cal_start), .cal_kind(cal_kind));
	adcsp_host_model host (.clk(clk), .sclk_pin_o(sclk_pin_o), .sclk_pin_oe_n(sclk_pin_oe_n),
		.serial_out_pin(serial_out_pin), .serial_out_pin_oe_n(serial_out_pin_oe_n),
		.sclk_pin_i(sclk_pin_i), .cs_n_pin(cs_n_pin));
	////////////////////////////////////////////////////////////
	// clock never stops
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watches the self clock shape and calibrate outputs; a hang is cut short here.
	always @(negedge clk) begin
		if (!sclk_pin_oe_n) begin
			act_cnt++;
			hi_cnt += sclk_pin_o;
		end
		cal_hits += cal_reset;
		start_cnt += cal_start;
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end
	task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk
	// Offset binary flips only the top bit of the filter's two's complement word.
	function automatic logic [19:0] expect_word(input logic [19:0] d);
		return bipolar_pin ? {~d[19], d[18:0]} : d;
	endfunction : expect_word
	task automatic push(input logic [19:0] d);
		@(negedge clk);
		result_valid = 1'b1;
		result_data = d;
		@(negedge clk);
		result_valid = 1'b0;
	endtask : push
	task automatic wait_low;
		for (int i = 0; i < 40 && word_valid_n !== 1'b0; i++) @(negedge clk);
		check("ready flag", word_valid_n, 1'b0);
	endtask : wait_low
	task automatic done(input string name);
		$display("Test %s done", name);
	endtask : done
	////////////////////////////////////////////////////////////
	// load pulse length
	task automatic t_load;
		int n;
		push(20'h12345);
		wait_low();
		push(20'h80001);
		n = 0;
		for (int i = 0; i < 20 && word_valid_n !== 1'b1; i++) @(negedge clk);
		while (word_valid_n === 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		check("pulse length", n, 4);
		done("load");
	endtask : t_load
	task automatic t_self(input logic [19:0] d);
		act_cnt = 0;
		hi_cnt = 0;
		host.read_self(20, w);
		wait_clk(3);
		check("self word", w, expect_word(d));
		check("clock cycles", act_cnt, 80);
		check("clock high", hi_cnt, 20);
		check("data released", serial_out_pin_oe_n, 1'b1);
		check("clock released", sclk_pin_oe_n, 1'b1);
		check("flag after word", word_valid_n, 1'b1);
		done("self");
	endtask : t_self
	task automatic t_cs_load;
		push(20'h0F0F0);
		wait_low();
		fork
			push(20'hA5A5A);
			begin
				wait_clk(2);
				host.read_self(20, w);
			end
		join
		check("late select word", w, expect_word(20'hA5A5A));
		done("cs_load");
	endtask : t_cs_load
	task automatic t_self_abort;
		push(20'h3A5C1);
		wait_low();
		host.read_self(3, w);
		check("partial self", w, expect_word(20'h3A5C1) >> 17);
		wait_clk(8);
		check("self data released", serial_out_pin_oe_n, 1'b1);
		check("self clock released", sclk_pin_oe_n, 1'b1);
		check("self word kept", word_valid_n, 1'b0);
		host.read_self(20, w);
		check("resent self", w, expect_word(20'h3A5C1));
		wait_clk(3);
		done("self_abort");
	endtask : t_self_abort
	task automatic t_busy;
		push(20'h11111);
		wait_low();
		fork
			host.read_self(20, w);
			begin
				wait_clk(30);
				push(20'h2EEE2);
				push(20'h2EEE2);
				check("buffer full", result_ready, 1'b0);
			end
		join
		check("old word", w, 20'h11111);
		wait_low();
		host.read_self(20, w);
		check("new word", w, 20'h2EEE2);
		done("busy");
	endtask : t_busy
	task automatic t_host;
		push(20'h6C3A9);
		wait_low();
		host.read_host(20, w);
		check("host word", w, 20'h6C3A9);
		wait_clk(5);
		check("data released", serial_out_pin_oe_n, 1'b1);
		check("flag after word", word_valid_n, 1'b1);
		@(negedge clk) host.deselect();
		done("host");
	endtask : t_host
	task automatic t_abort;
		push(20'hC0FFE);
		wait_low();
		host.read_host(5, w);
		check("partial bits", w, 20'h00018);
		wait_clk(5);
		check("data released", serial_out_pin_oe_n, 1'b1);
		check("word kept", word_valid_n, 1'b0);
		host.read_host(20, w);
		check("resent word", w, 20'hC0FFE);
		wait_clk(5);
		@(negedge clk) host.deselect();
		done("abort");
	endtask : t_abort
	task automatic t_cal;
		cal_hits = 0;
		@(negedge clk) {cal_select_a, cal_select_b, cal_pin} = 3'h3;
		wait_clk(4);
		cal_pin = 1'b0;
		wait_clk(6);
		check("short strobe", cal_hits, 0);
		check("user kind", cal_kind, 2'h0);
		start_cnt = 0;
		{cal_select_a, cal_select_b, cal_pin} = 3'h5;
		wait_clk(3);
		cal_select_b = 1'b1;
		wait_clk(7);
		check("cal reset", cal_reset, 1'b1);
		check("system kind", cal_kind, 2'h3);
		check("halted", conv_run, 1'b0);
		cal_pin = 1'b0;
		wait_clk(8);
		check("start pulses", start_cnt, 1);
		check("reset ended", cal_reset, 1'b0);
		done("cal");
	endtask : t_cal
	task automatic t_standby;
		standby_n_pin = 1'b0;
		wait_clk(4);
		check("standby run", conv_run, 1'b0);
		push(20'h54321);
		wait_clk(10);
		check("no word taken", word_valid_n, 1'b1);
		standby_n_pin = 1'b1;
		wait_clk(4);
		check("running", conv_run, 1'b1);
		done("standby");
	endtask : t_standby
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////
	// Link side reset needs falling link edges, so the host clock runs during reset.
	initial begin
		{rst_n, mode_pin, standby_n_pin, bipolar_pin, cal_pin} = 5'h0E;
		{cal_select_a, cal_select_b, result_valid} = 3'h6;
		result_data = 20'h00000;
		fork
			host.run_clock(20);
			wait_clk(3);
		join
		rst_n = 1'b1;
		wait_clk(3);
		check("idle data oe", serial_out_pin_oe_n, 1'b1);
		check("idle flag", word_valid_n, 1'b1);
		check("idle run", conv_run, 1'b1);
		t_load();
		t_self(20'h80001);
		t_cs_load();
		t_self_abort();
		bipolar_pin = 1'b0;
		t_busy();
		mode_pin = 1'b0;
		wait_clk(4);
		t_host();
		t_abort();
		t_cal();
		t_standby();
		final_report();
	end
endmodule : adc_serial_port_and_cal_control_test
`default_nettype wire
